// ### rtl/dcp_pkg.sv
// shared constants, command codes and types for the dram core link
`default_nettype none
package dcp_pkg;
  localparam int DQ_W = 8;
  localparam int ROW_W_X8 = 16;
  localparam int ROW_W_X16 = 15;
  localparam int BA_W = 3;
  localparam int NBANK = 8;
  localparam int FULL_CYC = 4;
  localparam int CHOP_CYC = 2;
  localparam int CL_CYC = 3;
  localparam int CWL_CYC = 2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int SRT_BIT = 7;
  localparam int ZQ_LONG_CYC = 16;
  localparam int ZQ_SHORT_CYC = 4;
  localparam int REFI_CYC = 400;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_ZQ = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [2:0] MR0_BA = 3'h0;
  localparam logic [2:0] MR2_BA = 3'h2;
  typedef enum logic [3:0] {
    OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_CLOSE_ALL_BANKS, OP_REF, OP_MRS,
    OP_ZQL, OP_ZQS, OP_PDE, OP_PDX, OP_SRE, OP_SRX
  } dcp_op_t;
  typedef enum logic [1:0] {FORM_MODE, FORM_CHOP, FORM_FULL} dcp_form_t;
  // sequential order, wraps inside each nibble, the start column's nibble first
  function automatic logic [2:0] burst_slot(input logic [2:0] s, input logic [2:0] i);
    return {s[2] ^ i[2], s[1:0] + i[1:0]};
  endfunction
endpackage
`default_nettype wire

// ### rtl/dcp_link_if.sv
// link between memory controller and memory device, with pin resolution
`timescale 1ns/10ps
`default_nettype none
interface dcp_link_if #(
  parameter int DQ_W = dcp_pkg::DQ_W,
  parameter int ROW_W = dcp_pkg::ROW_W_X8
);
  logic ck;
  logic ck_n;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [ROW_W-1:0] addr;
  logic [2*DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic ctl_dqs_o;
  logic ctl_dqs_oe;
  logic [2*DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic dev_dqs_o;
  logic dev_dqs_oe;
  logic [2*DQ_W-1:0] dq;
  logic dqs;
  logic dqs_n;
  assign ck_n = ~ck;
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  // an undriven strobe parks high, so a preamble shows as a low cycle
  assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : 1'b1);
  assign dqs_n = ~dqs;
  modport ctl (
    output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
    output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
    input ck_n, dq, dqs, dqs_n
  );
  modport dev (
    input ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq, dqs, dqs_n,
    output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe
  );
endinterface
`default_nettype wire

// ### rtl/dcp_mem_device.sv
// memory device end: command decode, bank state, burst engine, array
//
// Functional notes
// RQ1: burst moves one 8-beat core word, four cycles
// RQ2: controller centres write strobe in data eye; here the strobe rises with the data on the same ck fall
// RQ3: read data leaves together with its strobe
// RQ4: commands sampled on every rising link clock
// RQ5: first write beat on first strobe after preamble
// RQ6: first read beat follows the read preamble
// RQ7: burst starts at column, sequential wrapped order; writes start at the column's nibble boundary, low two bits zero
// RQ8: controller activates a row before access
// RQ9: activate picks bank and row
// RQ10: read or write picks bank and column
// RQ11: full burst eight and chopped burst four
// RQ12: auto close precharges row after burst
// RQ13: eight independent banks, overlapping bank commands
// RQ14: row address 16 bits x8, 15 bits x16
// RQ15: controller doubles refresh rate above 85C
// RQ16: controller sets hot self refresh before entry
// RQ17: controller refreshes eight times above 105C
// RQ18: no self refresh entry above 105C
// RQ19: fixed chop, fixed full, on-the-fly, autoclose forms
// RQ20: calibration, power down, self refresh, mode, precharge
// RQ21: single byte use carries data on lower lane
// RQ22: controller precharges before opening another row
`timescale 1ns/10ps
`default_nettype none
module dcp_mem_device #(
  parameter int DQ_W = dcp_pkg::DQ_W,
  parameter int ROW_W = dcp_pkg::ROW_W_X8,
  parameter int ARR_ROW_BITS = 1,
  parameter int ARR_COL_BITS = 1,
  parameter int CL = dcp_pkg::CL_CYC,
  parameter int ZQL = dcp_pkg::ZQ_LONG_CYC,
  parameter int ZQS = dcp_pkg::ZQ_SHORT_CYC
) (
  dcp_link_if.dev lnk,
  input wire logic sys_rst,
  output logic [dcp_pkg::NBANK-1:0] bank_open,
  output logic self_refresh,
  output logic power_down,
  output logic srt_on,
  output logic cal_busy,
  output logic [7:0] refresh_count
);
  localparam int WORD_W = 8 * DQ_W;
  localparam int IDX_W = 3 + ARR_ROW_BITS + ARR_COL_BITS;
  localparam int DEPTH = 1 << IDX_W;

  typedef enum {S_IDLE, S_RD_WAIT, S_RD_DATA, S_WR_WAIT, S_WR_DATA} dcp_dst_t;

  logic rst_m_q;
  logic rst_q;
  logic sr_q;
  logic pd_q;
  logic [1:0] bl_mode_q;
  logic srt_q;
  logic [dcp_pkg::NBANK-1:0] open_q;
  logic [ARR_ROW_BITS-1:0] row_q [dcp_pkg::NBANK];
  logic [7:0] zq_cnt_q;
  logic cal_q;
  logic [7:0] ref_cnt_q;
  dcp_dst_t st_q;
  logic [2:0] cnt_q;
  logic [2:0] beat_q;
  logic chop_q;
  logic ap_q;
  logic ap_fire_q;
  logic [2:0] bank_q;
  logic [2:0] start_q;
  logic [IDX_W-1:0] idx_q;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] mem_q [DEPTH];
  logic [2*DQ_W-1:0] dq_q;
  logic dq_oe_q;
  logic dqs_q;
  logic dqs_oe_q;
  logic [2:0] cmd;
  logic live;
  logic chop_now;
  logic [2:0] ncyc;
  logic [IDX_W-1:0] idx_now;
  logic [2*DQ_W-1:0] rd_pair;
  logic [WORD_W-1:0] wr_merge;

  // reset comes from the system domain, so it is retimed onto the link clock
  always_ff @(posedge lnk.ck) begin
    rst_m_q <= sys_rst;
    rst_q <= rst_m_q;
  end

  assign cmd = {lnk.ras_n, lnk.cas_n, lnk.we_n};
  assign live = !lnk.cs_n && lnk.cke && !sr_q && !pd_q; // RQ4
  assign chop_now = (bl_mode_q == dcp_pkg::BL_FIXED4) ||
                    (bl_mode_q == dcp_pkg::BL_OTF && !lnk.addr[dcp_pkg::BC_BIT]); // RQ19
  assign ncyc = chop_q ? 3'(dcp_pkg::CHOP_CYC) : 3'(dcp_pkg::FULL_CYC); // RQ11
  // only the low row bits reach the small model array
  assign idx_now = {lnk.ba, row_q[lnk.ba], lnk.addr[3 +: ARR_COL_BITS]}; // RQ10

  always_comb begin
    rd_pair = '0;
    wr_merge = word_q;
    for (int j = 0; j < 2; j++) begin
      rd_pair[j*DQ_W +: DQ_W] =
        word_q[dcp_pkg::burst_slot(start_q, {beat_q[1:0], 1'(j)})*DQ_W +: DQ_W]; // RQ7
      wr_merge[dcp_pkg::burst_slot(start_q, {beat_q[1:0], 1'(j)})*DQ_W +: DQ_W] =
        lnk.dq[j*DQ_W +: DQ_W]; // RQ1
    end
  end

  // power states: cke low with refresh enters self refresh, else power down
  always_ff @(posedge lnk.ck) begin
    if (rst_q) begin
      sr_q <= 1'b0;
      pd_q <= 1'b0;
    end else if (sr_q) begin
      if (lnk.cke) sr_q <= 1'b0; // RQ20
    end else if (pd_q) begin
      if (lnk.cke) pd_q <= 1'b0; // RQ20
    end else if (!lnk.cke && !lnk.cs_n && cmd == dcp_pkg::CMD_REF) begin
      sr_q <= 1'b1; // RQ20
    end else if (!lnk.cke) begin
      pd_q <= 1'b1; // RQ20
    end
  end

  always_ff @(posedge lnk.ck) begin
    if (rst_q) begin
      bl_mode_q <= dcp_pkg::BL_FIXED8;
      srt_q <= 1'b0;
    end else if (live && cmd == dcp_pkg::CMD_MRS) begin
      if (lnk.ba == dcp_pkg::MR0_BA) bl_mode_q <= lnk.addr[1:0]; // RQ20
      if (lnk.ba == dcp_pkg::MR2_BA) srt_q <= lnk.addr[dcp_pkg::SRT_BIT]; // RQ16
    end
  end

  // bank state runs apart from the burst engine so banks overlap
  always_ff @(posedge lnk.ck) begin
    if (rst_q) begin
      open_q <= '0;
      for (int b = 0; b < dcp_pkg::NBANK; b++) row_q[b] <= '0;
    end else begin
      if (live && cmd == dcp_pkg::CMD_ACT) begin
        open_q[lnk.ba] <= 1'b1; // RQ9
        row_q[lnk.ba] <= lnk.addr[ARR_ROW_BITS-1:0]; // RQ14
      end
      if (live && cmd == dcp_pkg::CMD_PRE) begin
        if (lnk.addr[dcp_pkg::AP_BIT]) open_q <= '0; // RQ20
        else open_q[lnk.ba] <= 1'b0; // RQ13
      end
      if (ap_fire_q) open_q[bank_q] <= 1'b0; // RQ12
    end
  end

  always_ff @(posedge lnk.ck) begin
    if (rst_q) begin
      zq_cnt_q <= 8'h00;
      cal_q <= 1'b0;
    end else if (live && cmd == dcp_pkg::CMD_ZQ) begin
      zq_cnt_q <= lnk.addr[dcp_pkg::AP_BIT] ? 8'(ZQL) : 8'(ZQS); // RQ20
      cal_q <= 1'b1;
    end else if (zq_cnt_q != 8'h00) begin
      zq_cnt_q <= zq_cnt_q - 8'h01;
      if (zq_cnt_q == 8'h01) cal_q <= 1'b0;
    end
  end

  always_ff @(posedge lnk.ck) begin
    if (rst_q) begin
      ref_cnt_q <= 8'h00;
    end else if (live && cmd == dcp_pkg::CMD_REF) begin
      ref_cnt_q <= ref_cnt_q + 8'h01; // RQ20
    end
  end

  // one burst in flight; commands for other banks still decode meanwhile
  always_ff @(posedge lnk.ck) begin
    if (rst_q) begin
      st_q <= S_IDLE;
      cnt_q <= 3'h0;
      beat_q <= 3'h0;
      chop_q <= 1'b0;
      ap_q <= 1'b0;
      ap_fire_q <= 1'b0;
      bank_q <= 3'h0;
      start_q <= 3'h0;
      idx_q <= '0;
      word_q <= '0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      dqs_q <= 1'b1;
      dqs_oe_q <= 1'b0;
    end else begin
      ap_fire_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (live && (cmd == dcp_pkg::CMD_RD || cmd == dcp_pkg::CMD_WR)) begin
            bank_q <= lnk.ba; // RQ10
            start_q <= (cmd == dcp_pkg::CMD_RD) ? lnk.addr[2:0] : {lnk.addr[2], 2'h0}; // RQ7
            idx_q <= idx_now;
            word_q <= mem_q[idx_now];
            chop_q <= chop_now; // RQ11
            ap_q <= lnk.addr[dcp_pkg::AP_BIT]; // RQ19
            cnt_q <= 3'(CL - 2);
            beat_q <= 3'h0;
            st_q <= (cmd == dcp_pkg::CMD_RD) ? S_RD_WAIT : S_WR_WAIT;
          end
        end
        S_RD_WAIT: begin
          if (cnt_q == 3'h0) begin
            dqs_oe_q <= 1'b1; // RQ6
            dqs_q <= 1'b0;
            st_q <= S_RD_DATA;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        S_RD_DATA: begin
          if (beat_q == ncyc) begin
            dq_oe_q <= 1'b0;
            dqs_oe_q <= 1'b0;
            dqs_q <= 1'b1;
            ap_fire_q <= ap_q; // RQ12
            st_q <= S_IDLE;
          end else begin
            dq_q <= rd_pair; // RQ3
            dq_oe_q <= 1'b1;
            dqs_q <= 1'b1; // RQ3
            beat_q <= beat_q + 3'h1; // RQ1
          end
        end
        S_WR_WAIT: begin
          if (!lnk.dqs) st_q <= S_WR_DATA; // RQ5
        end
        S_WR_DATA: begin
          if (lnk.dqs) begin
            word_q <= wr_merge; // RQ5
            beat_q <= beat_q + 3'h1;
            if (beat_q == ncyc - 3'h1) begin
              mem_q[idx_q] <= wr_merge; // RQ1
              ap_fire_q <= ap_q; // RQ12
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  assign lnk.dev_dq_o = dq_q;
  assign lnk.dev_dq_oe = dq_oe_q;
  assign lnk.dev_dqs_o = dqs_q;
  assign lnk.dev_dqs_oe = dqs_oe_q;
  assign bank_open = open_q;
  assign self_refresh = sr_q;
  assign power_down = pd_q;
  assign srt_on = srt_q;
  assign cal_busy = cal_q;
  assign refresh_count = ref_cnt_q;
endmodule
`default_nettype wire

// ### rtl/dcp_mem_ctrl.sv
// memory controller end: link clock divider, command issue, burst data
`timescale 1ns/10ps
`default_nettype none
module dcp_mem_ctrl #(
  parameter int DQ_W = dcp_pkg::DQ_W,
  parameter int ROW_W = dcp_pkg::ROW_W_X8,
  parameter int CWL = dcp_pkg::CWL_CYC,
  parameter int REFI = dcp_pkg::REFI_CYC,
  parameter bit LOWER_ONLY = 1'b0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire dcp_pkg::dcp_op_t req_op,
  input wire logic [2:0] req_bank,
  input wire logic [ROW_W-1:0] req_addr,
  input wire dcp_pkg::dcp_form_t req_form,
  input wire logic req_autopre,
  input wire logic [8*DQ_W-1:0] req_wdata,
  input wire logic temp_over_85,
  input wire logic temp_over_105,
  output logic req_ready,
  output logic req_refused,
  output logic rd_valid,
  output logic [8*DQ_W-1:0] rd_data,
  dcp_link_if.ctl lnk
);
  localparam int WORD_W = 8 * DQ_W;
  // lower lane only: upper four bits of each beat are never carried
  localparam logic [DQ_W-1:0] LANE = LOWER_ONLY ? DQ_W'({(DQ_W/2){1'b1}}) : '1;

  typedef enum {C_IDLE, C_REF, C_SRE, C_RD, C_WR} dcp_cst_t;

  logic ck_q;
  logic [1:0] t_m_q;
  logic [1:0] t_q;
  logic [15:0] ref_cnt_q;
  logic ref_due_q;
  dcp_cst_t st_q;
  logic [2:0] cmd_q;
  logic cke_q;
  logic [2:0] ba_q;
  logic [ROW_W-1:0] addr_q;
  logic [dcp_pkg::NBANK-1:0] open_q;
  logic [1:0] bl_mode_q;
  logic srt_q;
  logic in_sr_q;
  logic in_pd_q;
  logic [2:0] cnt_q;
  logic [2:0] beat_q;
  logic chop_q;
  logic ap_q;
  logic pre_q;
  logic [2:0] start_q;
  logic [WORD_W-1:0] word_q;
  logic [2*DQ_W-1:0] dq_q;
  logic dq_oe_q;
  logic dqs_q;
  logic dqs_oe_q;
  logic ready_q;
  logic refused_q;
  logic rd_valid_q;
  logic [WORD_W-1:0] rd_data_q;
  logic take;
  logic refuse;
  logic chop_now;
  logic [2:0] ncyc;
  logic [15:0] ref_lim;
  logic [2*DQ_W-1:0] drv_pair;
  logic [WORD_W-1:0] cap_word;

  // free-running divider, no reset, so the device sees edges during reset
  always_ff @(posedge clk_sys) begin
    if (ck_q) ck_q <= 1'b0;
    else ck_q <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    t_m_q <= {temp_over_105, temp_over_85};
    t_q <= t_m_q;
  end

  assign ref_lim = t_q[1] ? 16'(REFI / 8) : (t_q[0] ? 16'(REFI / 2) : 16'(REFI)); // RQ15 RQ17

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_cnt_q <= 16'h0000;
      ref_due_q <= 1'b0;
    end else begin
      if (ck_q && st_q == C_REF) ref_due_q <= 1'b0;
      if (ref_cnt_q >= ref_lim) begin
        ref_cnt_q <= 16'h0000;
        ref_due_q <= 1'b1; // RQ15
      end else begin
        ref_cnt_q <= ref_cnt_q + 16'h0001;
      end
    end
  end

  assign take = req_valid && ready_q;
  assign refuse =
    ((req_op == dcp_pkg::OP_READ || req_op == dcp_pkg::OP_WRITE) && !open_q[req_bank]) || // RQ8
    (req_op == dcp_pkg::OP_ACT && open_q[req_bank]) || // RQ22
    (req_op == dcp_pkg::OP_REF && open_q != '0) ||
    (req_op == dcp_pkg::OP_SRE && (t_q[1] || open_q != '0)) || // RQ18
    ((in_sr_q || in_pd_q) && req_op != dcp_pkg::OP_SRX && req_op != dcp_pkg::OP_PDX) ||
    (req_op == dcp_pkg::OP_SRX && !in_sr_q) ||
    (req_op == dcp_pkg::OP_PDX && !in_pd_q);
  assign chop_now = (bl_mode_q == dcp_pkg::BL_OTF) ? (req_form == dcp_pkg::FORM_CHOP) :
                    (bl_mode_q == dcp_pkg::BL_FIXED4);
  assign ncyc = chop_q ? 3'(dcp_pkg::CHOP_CYC) : 3'(dcp_pkg::FULL_CYC); // RQ11

  always_comb begin
    drv_pair = '0;
    cap_word = word_q;
    for (int j = 0; j < 2; j++) begin
      drv_pair[j*DQ_W +: DQ_W] = LANE &
        word_q[dcp_pkg::burst_slot(start_q, {beat_q[1:0], 1'(j)})*DQ_W +: DQ_W]; // RQ21
      cap_word[dcp_pkg::burst_slot(start_q, {beat_q[1:0], 1'(j)})*DQ_W +: DQ_W] =
        LANE & lnk.dq[j*DQ_W +: DQ_W];
    end
  end

  // all link outputs change when ck falls, half a cycle before the sampling rise
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= C_IDLE;
      cmd_q <= dcp_pkg::CMD_NOP;
      cke_q <= 1'b1;
      ba_q <= 3'h0;
      addr_q <= '0;
      open_q <= '0;
      bl_mode_q <= dcp_pkg::BL_FIXED8;
      srt_q <= 1'b0;
      in_sr_q <= 1'b0;
      in_pd_q <= 1'b0;
      cnt_q <= 3'h0;
      beat_q <= 3'h0;
      chop_q <= 1'b0;
      ap_q <= 1'b0;
      pre_q <= 1'b0;
      start_q <= 3'h0;
      word_q <= '0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      dqs_q <= 1'b1;
      dqs_oe_q <= 1'b0;
      ready_q <= 1'b0;
      refused_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      refused_q <= 1'b0;
      rd_valid_q <= 1'b0;
      ready_q <= !ck_q && st_q == C_IDLE && (!ref_due_q || in_sr_q || in_pd_q);
      if (ck_q) begin
        cmd_q <= dcp_pkg::CMD_NOP; // RQ4
        case (st_q)
          C_IDLE: begin
            if (take && refuse) begin
              refused_q <= 1'b1;
            end else if (take) begin
              ba_q <= req_bank;
              addr_q <= req_addr;
              case (req_op)
                dcp_pkg::OP_ACT: begin
                  cmd_q <= dcp_pkg::CMD_ACT; // RQ8
                  open_q[req_bank] <= 1'b1;
                end
                dcp_pkg::OP_READ, dcp_pkg::OP_WRITE: begin
                  cmd_q <= (req_op == dcp_pkg::OP_READ) ? dcp_pkg::CMD_RD : dcp_pkg::CMD_WR;
                  addr_q[dcp_pkg::AP_BIT] <= req_autopre; // RQ19
                  addr_q[dcp_pkg::BC_BIT] <= !chop_now; // RQ19
                  start_q <= (req_op == dcp_pkg::OP_READ) ? req_addr[2:0]
                                                           : {req_addr[2], 2'h0};
                  chop_q <= chop_now;
                  ap_q <= req_autopre;
                  word_q <= (req_op == dcp_pkg::OP_READ) ? '0 : req_wdata;
                  cnt_q <= 3'(CWL);
                  beat_q <= 3'h0;
                  pre_q <= 1'b0;
                  st_q <= (req_op == dcp_pkg::OP_READ) ? C_RD : C_WR;
                end
                dcp_pkg::OP_PRE: begin
                  cmd_q <= dcp_pkg::CMD_PRE; // RQ22
                  addr_q[dcp_pkg::AP_BIT] <= 1'b0;
                  open_q[req_bank] <= 1'b0;
                end
                dcp_pkg::OP_CLOSE_ALL_BANKS: begin
                  cmd_q <= dcp_pkg::CMD_PRE; // RQ20
                  addr_q[dcp_pkg::AP_BIT] <= 1'b1;
                  open_q <= '0;
                end
                dcp_pkg::OP_REF: cmd_q <= dcp_pkg::CMD_REF; // RQ20
                dcp_pkg::OP_MRS: begin
                  cmd_q <= dcp_pkg::CMD_MRS; // RQ20
                  if (req_bank == dcp_pkg::MR0_BA) bl_mode_q <= req_addr[1:0];
                  if (req_bank == dcp_pkg::MR2_BA) srt_q <= req_addr[dcp_pkg::SRT_BIT];
                end
                dcp_pkg::OP_ZQL, dcp_pkg::OP_ZQS: begin
                  cmd_q <= dcp_pkg::CMD_ZQ; // RQ20
                  addr_q[dcp_pkg::AP_BIT] <= (req_op == dcp_pkg::OP_ZQL);
                end
                dcp_pkg::OP_PDE: begin
                  cke_q <= 1'b0; // RQ20
                  in_pd_q <= 1'b1;
                end
                dcp_pkg::OP_PDX: begin
                  cke_q <= 1'b1; // RQ20
                  in_pd_q <= 1'b0;
                end
                dcp_pkg::OP_SRE: begin
                  if (t_q[0] && !srt_q) begin
                    cmd_q <= dcp_pkg::CMD_MRS; // RQ16
                    ba_q <= dcp_pkg::MR2_BA;
                    addr_q <= ROW_W'(1) << dcp_pkg::SRT_BIT;
                    srt_q <= 1'b1;
                    st_q <= C_SRE;
                  end else begin
                    cmd_q <= dcp_pkg::CMD_REF; // RQ20
                    cke_q <= 1'b0;
                    in_sr_q <= 1'b1;
                  end
                end
                dcp_pkg::OP_SRX: begin
                  cke_q <= 1'b1; // RQ20
                  in_sr_q <= 1'b0;
                end
                default: refused_q <= 1'b1;
              endcase
            end else if (ref_due_q && !in_sr_q && !in_pd_q) begin
              // open rows must close before the refresh goes out
              cmd_q <= dcp_pkg::CMD_PRE; // RQ22
              addr_q[dcp_pkg::AP_BIT] <= 1'b1;
              open_q <= '0;
              st_q <= C_REF;
            end
          end
          C_REF: begin
            cmd_q <= dcp_pkg::CMD_REF; // RQ15
            st_q <= C_IDLE;
          end
          C_SRE: begin
            cmd_q <= dcp_pkg::CMD_REF; // RQ16
            cke_q <= 1'b0;
            in_sr_q <= 1'b1;
            st_q <= C_IDLE;
          end
          C_WR: begin
            if (cnt_q != 3'h0) begin
              cnt_q <= cnt_q - 3'h1;
              if (cnt_q == 3'h1) begin
                dqs_oe_q <= 1'b1;
                dqs_q <= 1'b0;
              end
            end else if (beat_q == ncyc) begin
              dq_oe_q <= 1'b0;
              dqs_oe_q <= 1'b0;
              dqs_q <= 1'b1;
              if (ap_q) open_q[ba_q] <= 1'b0;
              st_q <= C_IDLE;
            end else begin
              dq_q <= drv_pair; // RQ2
              dq_oe_q <= 1'b1;
              dqs_q <= 1'b1; // RQ2
              beat_q <= beat_q + 3'h1;
            end
          end
          C_RD: begin
            if (!lnk.dqs) begin
              pre_q <= 1'b1;
            end else if (pre_q) begin
              word_q <= cap_word;
              beat_q <= beat_q + 3'h1;
              if (beat_q == ncyc - 3'h1) begin
                rd_data_q <= cap_word;
                rd_valid_q <= 1'b1;
                pre_q <= 1'b0;
                if (ap_q) open_q[ba_q] <= 1'b0; // RQ22
                st_q <= C_IDLE;
              end
            end
          end
          default: st_q <= C_IDLE;
        endcase
      end
    end
  end

  assign lnk.ck = ck_q;
  assign lnk.cke = cke_q;
  assign lnk.cs_n = 1'b0;
  assign lnk.ras_n = cmd_q[2];
  assign lnk.cas_n = cmd_q[1];
  assign lnk.we_n = cmd_q[0];
  assign lnk.ba = ba_q;
  assign lnk.addr = addr_q;
  assign lnk.ctl_dq_o = dq_q;
  assign lnk.ctl_dq_oe = dq_oe_q;
  assign lnk.ctl_dqs_o = dqs_q;
  assign lnk.ctl_dqs_oe = dqs_oe_q;
  assign req_ready = ready_q;
  assign req_refused = refused_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;
endmodule
`default_nettype wire

// ### dv/dcp_link_asserts.sv
// link checker: strobe framing on both ends, burst lengths on device reads
`timescale 1ns/10ps
`default_nettype none
module dcp_link_asserts (
  input wire logic ck,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic dqs,
  input wire logic ctl_dq_oe,
  input wire logic ctl_dqs_oe,
  input wire logic dev_dq_oe,
  input wire logic dev_dqs_oe,
  input wire logic dev_dqs_o
);
  default clocking @(posedge ck);
  endclocking
  default disable iff (sys_rst);
  logic [3:0] beats_q;
  logic go;
  assign go = !cs_n && cke && ras_n && !cas_n;
  sequence pre_s;
    dev_dqs_oe && !dev_dqs_o;
  endsequence
  sequence beat_s;
    dev_dq_oe && dev_dqs_o;
  endsequence
  // counts beat pairs so a short or long burst shows at its end
  always_ff @(posedge ck) begin
    beats_q <= dev_dq_oe ? beats_q + 4'h1 : 4'h0;
  end
  rd_preamble_a: assert property (go && we_n && !dev_dqs_oe |-> ##3 pre_s ##1 beat_s ##1 beat_s)
    else $error("read preamble or beats misplaced");
  rd_strobe_a: assert property (dev_dq_oe |-> dev_dqs_oe && dev_dqs_o)
    else $error("read data without strobe");
  beat_count_a: assert property ($fell(dev_dq_oe) |-> beats_q == 4'h2 || beats_q == 4'h4)
    else $error("read burst length wrong");
  first_beat_a: assert property ($rose(dev_dq_oe) |-> $past(dev_dqs_oe) && !$past(dev_dqs_o))
    else $error("first read beat without preamble");
  rd_release_a: assert property ($fell(dev_dq_oe) |-> !dev_dqs_oe)
    else $error("strobe held after read burst");
  wr_preamble_a: assert property (go && !we_n |-> ##2 (ctl_dqs_oe && !dqs) ##1 (ctl_dq_oe && dqs))
    else $error("write preamble or first beat misplaced");
  no_clash_a: assert property (!(dev_dq_oe && ctl_dq_oe))
    else $error("both ends drive data");
  rd_quiet_a: assert property (go && we_n && !dev_dqs_oe |-> (!ctl_dqs_oe)[*6])
    else $error("controller strobe during read");
endmodule
`default_nettype wire

// ### dv/ddr3_sdram_core_protocol_tb.sv
// bench: controller and device joined over the link, compared to a model
`timescale 1ns/10ps
`default_nettype none
module ddr3_sdram_core_protocol_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  dcp_pkg::dcp_op_t req_op = dcp_pkg::OP_ACT;
  logic [2:0] req_bank = 3'h0;
  logic [15:0] req_addr = 16'h0;
  dcp_pkg::dcp_form_t req_form = dcp_pkg::FORM_FULL;
  logic req_autopre = 1'b0;
  logic [63:0] req_wdata = 64'h0;
  logic [1:0] hot = 2'h0;
  logic req_ready, req_refused, rd_valid, srt;
  logic [63:0] rd_data;
  logic [7:0] n_ref;
  logic [31:0] lfsr_q = 32'h1849C;
  logic [63:0] mem [8];
  int err_total = 0;
  int n_compared = 0;
  dcp_link_if lnk ();
  always #10 clk_sys = ~clk_sys;
  // refresh interval kept long so the open-bank table stays put
  dcp_mem_ctrl #(.REFI(30000)) i_dcp_mem_ctrl (.clk_sys, .sys_rst, .req_valid, .req_op,
    .req_bank, .req_addr, .req_form, .req_autopre, .req_wdata, .temp_over_85(hot[0]),
    .temp_over_105(hot[1]), .req_ready, .req_refused, .rd_valid, .rd_data, .lnk(lnk));
  dcp_mem_device i_dcp_mem_device (.lnk(lnk), .sys_rst, .bank_open(), .self_refresh(),
    .power_down(), .srt_on(srt), .cal_busy(), .refresh_count(n_ref));
  dcp_link_asserts u_chk (.ck(lnk.ck), .sys_rst, .cke(lnk.cke), .cs_n(lnk.cs_n),
    .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .dqs(lnk.dqs),
    .ctl_dq_oe(lnk.ctl_dq_oe), .ctl_dqs_oe(lnk.ctl_dqs_oe), .dev_dq_oe(lnk.dev_dq_oe),
    .dev_dqs_oe(lnk.dev_dqs_oe), .dev_dqs_o(lnk.dev_dqs_o));
  function automatic void step();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
  endfunction
  task automatic chk_flag(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s exp %b got %b", nm, exp, got);
    end
  endtask
  task automatic chk_data(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  // refusal pulse may land in either cycle after the taking edge
  task automatic req(input dcp_pkg::dcp_op_t op, input logic [2:0] b, input logic [15:0] a,
      input dcp_pkg::dcp_form_t f, input logic ap, input logic nok);
    int n;
    logic r;
    @(negedge clk_sys);
    req_op = op;
    req_bank = b;
    req_addr = a;
    req_form = f;
    req_autopre = ap;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      n++;
      @(negedge clk_sys);
    end
    if (n == 200) err_total++;
    @(negedge clk_sys) req_valid = 1'b0;
    r = req_refused;
    @(negedge clk_sys) r = r | req_refused;
    chk_flag("refused", nok, r);
  endtask
  task automatic rd(input logic [2:0] b, input logic [2:0] s, input dcp_pkg::dcp_form_t f,
      input logic ap);
    int n;
    logic [2:0] k;
    req(dcp_pkg::OP_READ, b, {13'h0, s}, f, ap, 1'b0);
    n = 0;
    while (rd_valid !== 1'b1 && n < 120) begin
      n++;
      @(negedge clk_sys);
    end
    if (n == 120) err_total++;
    for (logic [3:0] i = 4'h0; i < (f == dcp_pkg::FORM_CHOP ? 4'h4 : 4'h8); i++) begin
      k = {s[2] ^ i[2], s[1:0] + i[1:0]};
      chk_data("rd_data", mem[b][k*8+:8], rd_data[k*8+:8]);
    end
  endtask
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  dcp_pkg::dcp_op_t ops [9] = '{dcp_pkg::OP_CLOSE_ALL_BANKS, dcp_pkg::OP_REF, dcp_pkg::OP_ZQL,
    dcp_pkg::OP_ZQS, dcp_pkg::OP_PDE, dcp_pkg::OP_PDX, dcp_pkg::OP_SRE, dcp_pkg::OP_SRX,
    dcp_pkg::OP_PDX};
  initial begin
    #1000000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'b0;
    repeat (8) @(negedge clk_sys);
    req(dcp_pkg::OP_MRS, dcp_pkg::MR0_BA, {14'h0, dcp_pkg::BL_OTF}, dcp_pkg::FORM_MODE, 1'b0, 1'b0);
    for (int b = 0; b < 8; b++) begin
      step();
      req(dcp_pkg::OP_ACT, b[2:0], lfsr_q[15:0], dcp_pkg::FORM_MODE, 1'b0, 1'b0);
      req(dcp_pkg::OP_ACT, b[2:0], 16'h0, dcp_pkg::FORM_MODE, 1'b0, 1'b1);
    end
    for (int b = 0; b < 8; b++) begin
      step();
      mem[b][31:0] = lfsr_q;
      step();
      mem[b][63:32] = lfsr_q;
      req_wdata = mem[b];
      req(dcp_pkg::OP_WRITE, b[2:0], 16'h0, dcp_pkg::FORM_FULL, 1'b0, 1'b0);
      rd(b[2:0], lfsr_q[2:0], dcp_pkg::FORM_FULL, 1'b0);
      rd(b[2:0], lfsr_q[5:3], dcp_pkg::FORM_CHOP, 1'b1);
      req(dcp_pkg::OP_READ, b[2:0], 16'h0, dcp_pkg::FORM_FULL, 1'b0, 1'b1);
    end
    // power down refuses a second exit
    for (int i = 0; i < 9; i++) begin
      req(ops[i], 3'h0, 16'h0, dcp_pkg::FORM_MODE, 1'b0, i == 8);
    end
    hot = 2'h3;
    repeat (4) @(negedge clk_sys);
    req(dcp_pkg::OP_SRE, 3'h0, 16'h0, dcp_pkg::FORM_MODE, 1'b0, 1'b1);
    hot = 2'h1;
    repeat (4) @(negedge clk_sys);
    req(dcp_pkg::OP_SRE, 3'h0, 16'h0, dcp_pkg::FORM_MODE, 1'b0, 1'b0);
    chk_flag("srt_on", 1'b1, srt);
    chk_data("refresh_count", 8'h01, n_ref);
    summarize();
  end
endmodule
`default_nettype wire
